// File: rtl/vsp_cfg.svh
// Purpose: Named constants for the valve controller serial host port
// Assumes: 100 MHz system clock
// Notes:   Switch vectors hold pole 1 in bit 0
`ifndef VSP_CFG_SVH
`define VSP_CFG_SVH

`define VSP_SYS_CLK_HZ   100000000
`define VSP_ZERO_HOLD_MS 10

// Baud rates in bits per second
`define VSP_RATE_300     300
`define VSP_RATE_600     600
`define VSP_RATE_1200    1200
`define VSP_RATE_1800    1800
`define VSP_RATE_2400    2400
`define VSP_RATE_4800    4800
`define VSP_RATE_9600    9600

// Baud switch codes, {pole4, pole3, pole2, pole1}
`define VSP_BSW_300      4'h2
`define VSP_BSW_600      4'h9
`define VSP_BSW_1200     4'h4
`define VSP_BSW_1800     4'h5
`define VSP_BSW_2400     4'h8
`define VSP_BSW_4800     4'h6
`define VSP_BSW_9600     4'h7

// Framing switch pole positions
`define VSP_FSW_LEN      0
`define VSP_FSW_ODD      1
`define VSP_FSW_STOP     2
`define VSP_FSW_PAR      3

// Last data bit index for 7 and 8 data bits
`define VSP_LAST_7       3'h6
`define VSP_LAST_8       3'h7
`define VSP_CFG_SETTLE   2'h3
`define VSP_SP_ZERO      12'h000

`endif

// File: rtl/vsp_pkg.sv
// Purpose: Types shared by the serial host port
// Assumes: vsp_cfg.svh constants
// Notes:   None
package vsp_pkg;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} vsp_rx_st_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} vsp_tx_st_t;

   // Override commands from the host-side parser
   typedef enum logic [2:0] {OVR_AUTO, OVR_OPEN, OVR_CLOSE, OVR_HALT, OVR_SOFT, OVR_ZERO,
                             OVR_POSN} vsp_ovr_cmd_t;

   typedef struct packed {
      logic       seven;
      logic       par_en;
      logic       par_odd;
      logic       two_stop;
      logic [3:0] baud;
   } vsp_frame_t;

   typedef struct packed {
      logic [7:0] data;
      logic       par_err;
      logic       frame_err;
   } vsp_rx_byte_t;

   // Interface lines, active low like a grounded pin
   typedef struct packed {
      logic open_n;
      logic close_n;
      logic halt_n;
      logic soft_n;
      logic auto_n;
      logic zero_n;
      logic posn_n;
   } vsp_ovr_t;

endpackage

// File: rtl/vsp_serial_port.sv
// Purpose: Asynchronous serial host port of the valve controller
// Assumes: Single 100 MHz clock; switches only change while unpowered
// Notes:   Command text parsing lives outside; this block moves bytes,
//          latches overrides and selects the active set point
//
// What this block does
// - Ignore received traffic unless mode is remote
// - Default framing 7E1 at 9600 baud
// - Pole 1 closed 7 bits, open 8
// - Pole 4 closed enables parity, pole 2 odd
// - Pole 4 open: no parity, ignore pole 2
// - Pole 3 closed one stop, open two
// - Baud switch codes select seven rates
// - Internal source: set point from serial link
// - External source: set point from analog input
// - Only data lines needed, no handshakes
// - Report values to host on request
// - Accept set point and override commands
`timescale 1ns/1ns
`default_nettype none
`include "vsp_cfg.svh"

module vsp_serial_port
   import vsp_pkg::*;
#(
   parameter int BIT_CYC_300   = `VSP_SYS_CLK_HZ / `VSP_RATE_300,
   parameter int BIT_CYC_600   = `VSP_SYS_CLK_HZ / `VSP_RATE_600,
   parameter int BIT_CYC_1200  = `VSP_SYS_CLK_HZ / `VSP_RATE_1200,
   parameter int BIT_CYC_1800  = `VSP_SYS_CLK_HZ / `VSP_RATE_1800,
   parameter int BIT_CYC_2400  = `VSP_SYS_CLK_HZ / `VSP_RATE_2400,
   parameter int BIT_CYC_4800  = `VSP_SYS_CLK_HZ / `VSP_RATE_4800,
   parameter int BIT_CYC_9600  = `VSP_SYS_CLK_HZ / `VSP_RATE_9600,
   parameter int ZERO_HOLD_CYC = (`VSP_SYS_CLK_HZ / 1000) * `VSP_ZERO_HOLD_MS
)(
   input  wire logic         i_sys_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_rxd,
   output var  logic         o_txd,
   input  wire logic         i_remote_mode,
   input  wire logic [3:0]   i_frame_sw,
   input  wire logic [3:0]   i_baud_sw,
   input  wire logic         i_ext_sp_sel,
   output var  vsp_rx_byte_t o_rx_byte,
   output var  logic         o_rx_valid,
   input  wire logic [7:0]   i_tx_data,
   input  wire logic         i_tx_valid,
   output var  logic         o_tx_ready,
   input  wire logic         i_sp_load,
   input  wire logic [11:0]  i_sp_value,
   input  wire logic [11:0]  i_ext_setpoint,
   output var  logic [11:0]  o_setpoint,
   input  wire logic         i_ovr_valid,
   input  wire vsp_ovr_cmd_t i_ovr_cmd,
   output var  vsp_ovr_t     o_ovr,
   output var  vsp_frame_t   o_frame,
   output var  logic         o_cfg_done
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic         rxd_m;
      logic         rxd_s;
      logic         mode_m;
      logic         mode_s;
      logic [7:0]   sw_m;
      logic [7:0]   sw_s;
      logic         ext_m;
      logic         ext_s;
      logic [1:0]   settle;
      logic         cfg_done;
      vsp_frame_t   frame;
      vsp_rx_st_t   rx_st;
      logic [18:0]  rx_cnt;
      logic [2:0]   rx_idx;
      logic [7:0]   rx_sh;
      logic         rx_perr;
      vsp_rx_byte_t rx_byte;
      logic         rx_valid;
      vsp_tx_st_t   tx_st;
      logic [18:0]  tx_cnt;
      logic [2:0]   tx_idx;
      logic [7:0]   tx_sh;
      logic         tx_stop2;
      logic         tx_ready;
      logic         txd;
      logic [11:0]  link_sp;
      logic [11:0]  setpoint;
      vsp_ovr_t     ovr;
      logic [19:0]  pulse_cnt;
   } vsp_state_t;

   localparam vsp_frame_t FRAME_DFLT = '{seven: 1'b1, par_en: 1'b1, par_odd: 1'b0,
                                         two_stop: 1'b0, baud: `VSP_BSW_9600};
   localparam vsp_state_t ST_RST = '{
      rxd_m: 1'b1, rxd_s: 1'b1, mode_m: 1'b0, mode_s: 1'b0,
      sw_m: 8'h00, sw_s: 8'h00, ext_m: 1'b0, ext_s: 1'b0,
      settle: 2'h0, cfg_done: 1'b0, frame: FRAME_DFLT,
      rx_st: RX_IDLE, rx_cnt: 19'h00000, rx_idx: 3'h0, rx_sh: 8'h00, rx_perr: 1'b0,
      rx_byte: '{data: 8'h00, par_err: 1'b0, frame_err: 1'b0}, rx_valid: 1'b0,
      tx_st: TX_IDLE, tx_cnt: 19'h00000, tx_idx: 3'h0, tx_sh: 8'h00, tx_stop2: 1'b0,
      tx_ready: 1'b0, txd: 1'b1, link_sp: `VSP_SP_ZERO, setpoint: `VSP_SP_ZERO,
      ovr: 7'h7F, pulse_cnt: 20'h00000};

   vsp_state_t s;
   vsp_state_t next_s;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Bit period less one; reserved codes run at 9600
   function automatic logic [18:0] bit_cycles(input logic [3:0] code);
      unique case (code)
         `VSP_BSW_300:  bit_cycles = 19'(BIT_CYC_300 - 1);
         `VSP_BSW_600:  bit_cycles = 19'(BIT_CYC_600 - 1);
         `VSP_BSW_1200: bit_cycles = 19'(BIT_CYC_1200 - 1);
         `VSP_BSW_1800: bit_cycles = 19'(BIT_CYC_1800 - 1);
         `VSP_BSW_2400: bit_cycles = 19'(BIT_CYC_2400 - 1);
         `VSP_BSW_4800: bit_cycles = 19'(BIT_CYC_4800 - 1);
         default:       bit_cycles = 19'(BIT_CYC_9600 - 1);
      endcase
   endfunction

   // Parity bit over the active data bits
   function automatic logic par_bit(input vsp_frame_t f, input logic [7:0] d);
      logic [7:0] m;
      m = f.seven ? {1'b0, d[6:0]} : d;
      par_bit = (^m) ^ f.par_odd;
   endfunction

   function automatic logic [2:0] last_idx(input vsp_frame_t f);
      last_idx = f.seven ? `VSP_LAST_7 : `VSP_LAST_8;
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      // Two-stage synchronisers for pins and switches
      next_s.rxd_m  = i_rxd;
      next_s.rxd_s  = s.rxd_m;
      next_s.mode_m = i_remote_mode;
      next_s.mode_s = s.mode_m;
      next_s.sw_m   = {i_frame_sw, i_baud_sw};
      next_s.sw_s   = s.sw_m;
      next_s.ext_m  = i_ext_sp_sel;
      next_s.ext_s  = s.ext_m;
      next_s.rx_valid = 1'b0;

      // One capture after reset, once the synchronisers have filled
      if (!s.cfg_done)
      begin
         if (s.settle == `VSP_CFG_SETTLE)
         begin
            next_s.cfg_done       = 1'b1;
            next_s.frame.seven    = s.sw_s[4 + `VSP_FSW_LEN];
            next_s.frame.par_en   = s.sw_s[4 + `VSP_FSW_PAR];
            next_s.frame.par_odd  = s.sw_s[4 + `VSP_FSW_PAR] & s.sw_s[4 + `VSP_FSW_ODD];
            next_s.frame.two_stop = !s.sw_s[4 + `VSP_FSW_STOP];
            next_s.frame.baud     = s.sw_s[3:0];
         end
         else
         begin
            next_s.settle = s.settle + 2'h1;
         end
      end

      // Receiver: samples mid-bit, data and ground lines only
      unique case (s.rx_st)
         RX_IDLE:
         begin
            if (s.cfg_done && !s.rxd_s)
            begin
               next_s.rx_st  = RX_START;
               next_s.rx_cnt = bit_cycles(s.frame.baud) >> 1;
            end
         end
         RX_START:
         begin
            if (s.rx_cnt != 19'h00000)
               next_s.rx_cnt = s.rx_cnt - 19'h00001;
            else if (s.rxd_s)
               next_s.rx_st = RX_IDLE; // Glitch, not a start bit
            else
            begin
               next_s.rx_st  = RX_DATA;
               next_s.rx_cnt = bit_cycles(s.frame.baud);
               next_s.rx_idx = 3'h0;
               next_s.rx_sh  = 8'h00;
               next_s.rx_perr = 1'b0;
            end
         end
         RX_DATA:
         begin
            if (s.rx_cnt != 19'h00000)
               next_s.rx_cnt = s.rx_cnt - 19'h00001;
            else
            begin
               next_s.rx_sh[s.rx_idx] = s.rxd_s;
               next_s.rx_idx = s.rx_idx + 3'h1;
               next_s.rx_cnt = bit_cycles(s.frame.baud);
               if (s.rx_idx == last_idx(s.frame))
                  next_s.rx_st = s.frame.par_en ? RX_PAR : RX_STOP;
            end
         end
         RX_PAR:
         begin
            if (s.rx_cnt != 19'h00000)
               next_s.rx_cnt = s.rx_cnt - 19'h00001;
            else
            begin
               next_s.rx_perr = s.rxd_s != par_bit(s.frame, s.rx_sh);
               next_s.rx_cnt  = bit_cycles(s.frame.baud);
               next_s.rx_st   = RX_STOP;
            end
         end
         RX_STOP:
         begin
            if (s.rx_cnt != 19'h00000)
               next_s.rx_cnt = s.rx_cnt - 19'h00001;
            else
            begin
               // Only the first stop bit is checked, so 2-stop hosts also pass
               next_s.rx_st = RX_IDLE;
               if (s.mode_s)
               begin
                  next_s.rx_valid          = 1'b1;
                  next_s.rx_byte.data      = s.rx_sh;
                  next_s.rx_byte.par_err   = s.rx_perr;
                  next_s.rx_byte.frame_err = !s.rxd_s;
               end
            end
         end
      endcase

      // Transmitter for replies
      unique case (s.tx_st)
         TX_IDLE:
         begin
            next_s.tx_ready = s.cfg_done;
            if (s.tx_ready && i_tx_valid)
            begin
               next_s.tx_ready = 1'b0;
               next_s.tx_sh    = i_tx_data;
               next_s.txd      = 1'b0;
               next_s.tx_cnt   = bit_cycles(s.frame.baud);
               next_s.tx_st    = TX_START;
            end
         end
         TX_START:
         begin
            if (s.tx_cnt != 19'h00000)
               next_s.tx_cnt = s.tx_cnt - 19'h00001;
            else
            begin
               next_s.txd    = s.tx_sh[0];
               next_s.tx_idx = 3'h0;
               next_s.tx_cnt = bit_cycles(s.frame.baud);
               next_s.tx_st  = TX_DATA;
            end
         end
         TX_DATA:
         begin
            if (s.tx_cnt != 19'h00000)
               next_s.tx_cnt = s.tx_cnt - 19'h00001;
            else
            begin
               next_s.tx_cnt = bit_cycles(s.frame.baud);
               if (s.tx_idx == last_idx(s.frame))
               begin
                  next_s.tx_stop2 = s.frame.two_stop;
                  if (s.frame.par_en)
                  begin
                     next_s.txd   = par_bit(s.frame, s.tx_sh);
                     next_s.tx_st = TX_PAR;
                  end
                  else
                  begin
                     next_s.txd   = 1'b1;
                     next_s.tx_st = TX_STOP;
                  end
               end
               else
               begin
                  next_s.tx_idx = s.tx_idx + 3'h1;
                  next_s.txd    = s.tx_sh[s.tx_idx + 3'h1];
               end
            end
         end
         TX_PAR:
         begin
            if (s.tx_cnt != 19'h00000)
               next_s.tx_cnt = s.tx_cnt - 19'h00001;
            else
            begin
               next_s.txd    = 1'b1;
               next_s.tx_cnt = bit_cycles(s.frame.baud);
               next_s.tx_st  = TX_STOP;
            end
         end
         TX_STOP:
         begin
            if (s.tx_cnt != 19'h00000)
               next_s.tx_cnt = s.tx_cnt - 19'h00001;
            else if (s.tx_stop2)
            begin
               next_s.tx_stop2 = 1'b0;
               next_s.tx_cnt   = bit_cycles(s.frame.baud);
            end
            else
               next_s.tx_st = TX_IDLE;
         end
      endcase

      // Momentary lines stay low for the zero hold time
      if (s.pulse_cnt != 20'h00000)
         next_s.pulse_cnt = s.pulse_cnt - 20'h00001;
      else
      begin
         next_s.ovr.soft_n = 1'b1;
         next_s.ovr.auto_n = 1'b1;
         next_s.ovr.zero_n = 1'b1;
      end

      // Valve commands latch until auto, position or another valve command
      if (i_ovr_valid && s.mode_s)
      begin
         unique case (i_ovr_cmd)
            OVR_OPEN, OVR_CLOSE, OVR_HALT, OVR_POSN:
            begin
               next_s.ovr.open_n  = i_ovr_cmd != OVR_OPEN;
               next_s.ovr.close_n = i_ovr_cmd != OVR_CLOSE;
               next_s.ovr.halt_n  = i_ovr_cmd != OVR_HALT;
               next_s.ovr.posn_n  = i_ovr_cmd != OVR_POSN;
            end
            OVR_AUTO:
            begin
               next_s.ovr        = 7'h7F;
               next_s.ovr.auto_n = 1'b0;
               next_s.pulse_cnt  = 20'(ZERO_HOLD_CYC - 1);
            end
            OVR_SOFT:
            begin
               next_s.ovr.soft_n = 1'b0;
               next_s.pulse_cnt  = 20'(ZERO_HOLD_CYC - 1);
            end
            OVR_ZERO:
            begin
               next_s.ovr.zero_n = 1'b0;
               next_s.pulse_cnt  = 20'(ZERO_HOLD_CYC - 1);
            end
            default:
            begin
               next_s.ovr = s.ovr;
            end
         endcase
      end

      // Active set point
      if (i_sp_load && s.mode_s)
         next_s.link_sp = i_sp_value;
      next_s.setpoint = s.ext_s ? i_ext_setpoint : s.link_sp;
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         s <= ST_RST;
      else
         s <= next_s;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_txd      = s.txd;
   assign o_rx_byte  = s.rx_byte;
   assign o_rx_valid = s.rx_valid;
   assign o_tx_ready = s.tx_ready;
   assign o_setpoint = s.setpoint;
   assign o_ovr      = s.ovr;
   assign o_frame    = s.frame;
   assign o_cfg_done = s.cfg_done;

endmodule // vsp_serial_port

`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench for the serial host port
// Assumes: Shortened bit periods and hold count
// Notes:   Switches are changed through a fresh reset, except once without reset to check the frame is held
`timescale 1ns/1ns
`default_nettype none
module tb
   import vsp_pkg::*;
;
   localparam int ZH = 8;
   logic         i_sys_clk      = 1'b0;
   logic         i_resetn       = 1'b0;
   logic         i_rxd;
   logic         o_txd;
   logic         i_remote_mode  = 1'b1;
   logic [3:0]   i_frame_sw     = 4'hD;
   logic [3:0]   i_baud_sw      = 4'h7;
   logic         i_ext_sp_sel   = 1'b0;
   vsp_rx_byte_t o_rx_byte;
   logic         o_rx_valid;
   logic [7:0]   i_tx_data;
   logic         i_tx_valid     = 1'b0;
   logic         o_tx_ready;
   logic         i_sp_load      = 1'b0;
   logic [11:0]  i_sp_value;
   logic [11:0]  i_ext_setpoint;
   logic [11:0]  o_setpoint;
   logic         i_ovr_valid    = 1'b0;
   vsp_ovr_cmd_t i_ovr_cmd;
   vsp_ovr_t     o_ovr;
   vsp_frame_t   o_frame;
   logic         o_cfg_done;
   int           fails = 0;
   int           samples_checked = 0;
   int           rx_cnt = 0;
   vsp_rx_byte_t rx_got;
   logic [3:0]   cf_f [8] = '{4'hD, 4'hF, 4'h2, 4'hA, 4'hC, 4'h1, 4'h6, 4'hD};
   logic [3:0]   cf_b [8] = '{4'h7, 4'h2, 4'h9, 4'h4, 4'h5, 4'h8, 4'h6, 4'hF};
   int           cf_c [8] = '{16, 40, 36, 32, 28, 24, 20, 16};
   vsp_ovr_cmd_t oc [7]   = '{OVR_OPEN, OVR_CLOSE, OVR_HALT, OVR_POSN, OVR_AUTO, OVR_SOFT, OVR_ZERO};
   logic [6:0]   o_now [7] = '{7'h3F, 7'h5F, 7'h6F, 7'h7E, 7'h7B, 7'h77, 7'h7D};
   logic [6:0]   o_aft [7] = '{7'h3F, 7'h5F, 7'h6F, 7'h7E, 7'h7F, 7'h7F, 7'h7F};
   vsp_serial_port #(.BIT_CYC_300(40), .BIT_CYC_600(36), .BIT_CYC_1200(32), .BIT_CYC_1800(28),
      .BIT_CYC_2400(24), .BIT_CYC_4800(20), .BIT_CYC_9600(16), .ZERO_HOLD_CYC(ZH))
   i_vsp_serial_port (.i_sys_clk, .i_resetn, .i_rxd, .o_txd, .i_remote_mode, .i_frame_sw,
      .i_baud_sw, .i_ext_sp_sel, .o_rx_byte, .o_rx_valid, .i_tx_data, .i_tx_valid, .o_tx_ready,
      .i_sp_load, .i_sp_value, .i_ext_setpoint, .o_setpoint, .i_ovr_valid, .i_ovr_cmd, .o_ovr,
      .o_frame, .o_cfg_done);
   vsp_host_model i_vsp_host_model (.i_sys_clk, .i_txd(o_txd), .o_rxd(i_rxd));
   always #5 i_sys_clk = ~i_sys_clk;
   always @(negedge i_sys_clk)
      if (o_rx_valid === 1'b1)
      begin
         rx_cnt++;
         rx_got = o_rx_byte;
      end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [11:0] ex, input logic [11:0] got);
      samples_checked++;
      if (got !== ex)
      begin
         $display("mismatch %s expected %h seen %h", what, ex, got);
         fails++;
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic do_reset(input logic [3:0] f, input logic [3:0] b);
      int t;
      t = 0;
      @(posedge i_sys_clk);
      i_resetn   <= 1'b0;
      i_frame_sw <= f;
      i_baud_sw  <= b;
      repeat (5) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      while (o_cfg_done !== 1'b1 && t < 50)
      begin
         @(negedge i_sys_clk);
         t++;
      end
      check("cfg_done", 12'h001, {11'h000, o_cfg_done});
   endtask
   task automatic dev_tx(input logic [7:0] d, output logic [7:0] got, output logic ok);
      fork
         i_vsp_host_model.recv(got, ok);
         begin
            @(posedge i_sys_clk);
            i_tx_data  <= d;
            i_tx_valid <= 1'b1;
            for (int t = 0; t < 200 && o_tx_ready !== 1'b1; t++)
               @(negedge i_sys_clk);
            @(posedge i_sys_clk);
            i_tx_valid <= 1'b0;
         end
      join
   endtask
   task automatic pulse(input logic sp, input vsp_ovr_cmd_t c, input logic [11:0] v);
      @(posedge i_sys_clk);
      i_sp_load   <= sp;
      i_ovr_valid <= !sp;
      i_ovr_cmd   <= c;
      i_sp_value  <= v;
      @(posedge i_sys_clk);
      i_sp_load   <= 1'b0;
      i_ovr_valid <= 1'b0;
      repeat (2) @(negedge i_sys_clk);
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      int         n0;
      logic [7:0] got;
      logic [7:0] ex;
      logic       ok;
      logic [3:0] f;
      for (int k = 0; k < 8; k++)
      begin
         f = cf_f[k];
         do_reset(f, cf_b[k]);
         i_vsp_host_model.bit_cyc = cf_c[k];
         i_vsp_host_model.cfg = {f[0], f[3], f[3] & f[1], ~f[2], 4'h0};
         check("frame", {8'h00, i_vsp_host_model.cfg[7:4]}, {8'h00, o_frame[7:4]});
         if (k == 0)
            check("default frame", 12'h0C7, {4'h0, o_frame});
         for (int e = 0; e < (f[3] ? 2 : 1); e++)
         begin
            n0 = rx_cnt;
            ex = 8'hA5 ^ 8'(k);
            i_vsp_host_model.send(ex, e[0]);
            repeat (cf_c[k] + 8) @(negedge i_sys_clk);
            if (f[0])
               ex[7] = 1'b0;
            check("rx count", 12'(n0 + 1), 12'(rx_cnt));
            check("rx data", {4'h0, ex}, {4'h0, rx_got.data});
            check("rx errors", {10'h000, e[0], 1'b0}, {10'h000, rx_got.par_err, rx_got.frame_err});
         end
         ex = 8'hC3 + 8'(k);
         dev_tx(ex, got, ok);
         if (f[0])
            ex[7] = 1'b0;
         check("tx data", {4'h0, ex}, {4'h0, got});
         check("tx frame", 12'h001, {11'h000, ok});
         if (k == 0)
         begin
            @(posedge i_sys_clk);
            i_frame_sw <= 4'h0;
            i_baud_sw  <= 4'h2;
            repeat (6) @(negedge i_sys_clk);
            check("frame held", 12'h0C7, {4'h0, o_frame});
         end
         $display("framing test %0d done", k);
      end
      i_remote_mode <= 1'b0;
      n0 = rx_cnt;
      i_vsp_host_model.send(8'h5A, 1'b0);
      repeat (30) @(negedge i_sys_clk);
      check("rx local", 12'(n0), 12'(rx_cnt));
      pulse(1'b0, OVR_OPEN, 12'h000);
      check("ovr local", 12'h07F, {5'h00, o_ovr});
      pulse(1'b1, OVR_AUTO, 12'h123);
      check("sp local", 12'h000, o_setpoint);
      i_remote_mode <= 1'b1;
      repeat (6) @(negedge i_sys_clk);
      pulse(1'b1, OVR_AUTO, 12'hABC);
      check("sp link", 12'hABC, o_setpoint);
      i_ext_sp_sel   <= 1'b1;
      i_ext_setpoint <= 12'h5A5;
      pulse(1'b1, OVR_AUTO, 12'h321);
      repeat (4) @(negedge i_sys_clk);
      check("sp ext", 12'h5A5, o_setpoint);
      $display("gating and set point test done");
      for (int c = 0; c < 7; c++)
      begin
         pulse(1'b0, oc[c], 12'h000);
         check("ovr now", {5'h00, o_now[c]}, {5'h00, o_ovr});
         repeat (ZH + 4) @(negedge i_sys_clk);
         check("ovr after", {5'h00, o_aft[c]}, {5'h00, o_ovr});
      end
      $display("override test done");
      print_verdict();
   end
   initial
   begin
      repeat (80000) @(posedge i_sys_clk);
      fails++;
      print_verdict();
   end
endmodule // tb
bind vsp_serial_port vsp_port_properties #(.ZERO_HOLD_CYC(ZERO_HOLD_CYC)) i_vsp_port_properties (
   .i_sys_clk, .i_resetn, .o_txd, .i_remote_mode, .i_frame_sw, .i_baud_sw, .i_ext_sp_sel,
   .o_rx_valid, .i_tx_valid, .o_tx_ready, .i_sp_load, .i_sp_value, .i_ext_setpoint,
   .o_setpoint, .i_ovr_valid, .i_ovr_cmd, .o_ovr, .o_frame, .o_cfg_done);
`default_nettype wire

// File: verif/vsp_host_model.sv
// Purpose: Host computer at the far end of the serial link
// Assumes: Bench sets bit_cyc and cfg to match the switches
// Notes:   Uses only the two data lines; idle line is mark
`timescale 1ns/1ns
`default_nettype none
module vsp_host_model
   import vsp_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_txd,
   output var  logic o_rxd
);
   int         bit_cyc = 16;
   vsp_frame_t cfg     = 8'hC7;
   initial o_rxd = 1'b1;
   task automatic put(input logic v);
      o_rxd <= v;
      repeat (bit_cyc) @(posedge i_sys_clk);
   endtask
   // Frame out: start, data LSB first, optional parity, stops
   task automatic send(input logic [7:0] b, input logic bad_par);
      logic p;
      p = (cfg.seven ? ^b[6:0] : ^b) ^ cfg.par_odd ^ bad_par;
      @(posedge i_sys_clk);
      put(1'b0);
      for (int i = 0; i < (cfg.seven ? 7 : 8); i++)
         put(b[i]);
      if (cfg.par_en)
         put(p);
      put(1'b1);
      if (cfg.two_stop)
         put(1'b1);
   endtask
   // Frame in, sampled at bit centres
   task automatic recv(output logic [7:0] b, output logic ok);
      int t;
      b  = '0;
      t  = 0;
      while (i_txd !== 1'b0 && t < 4000)
      begin
         @(negedge i_sys_clk);
         t++;
      end
      repeat (bit_cyc / 2) @(negedge i_sys_clk);
      ok = (i_txd === 1'b0);
      for (int i = 0; i < (cfg.seven ? 7 : 8); i++)
      begin
         repeat (bit_cyc) @(negedge i_sys_clk);
         b[i] = i_txd;
      end
      if (cfg.par_en)
      begin
         repeat (bit_cyc) @(negedge i_sys_clk);
         ok = ok && (i_txd === ((cfg.seven ? ^b[6:0] : ^b) ^ cfg.par_odd));
      end
      repeat (bit_cyc) @(negedge i_sys_clk);
      ok = ok && (i_txd === 1'b1);
      if (cfg.two_stop)
      begin
         repeat (bit_cyc) @(negedge i_sys_clk);
         ok = ok && (i_txd === 1'b1);
      end
   endtask
endmodule // vsp_host_model
`default_nettype wire

// File: verif/vsp_port_properties.sv
// Purpose: Concurrent checks on the serial host port pins
// Assumes: One clock domain; switches stable while the capture runs
// Notes:   Attached by bind from the bench top file
`timescale 1ns/1ns
`default_nettype none
module vsp_port_properties
   import vsp_pkg::*;
#(
   parameter int ZERO_HOLD_CYC = 8
)(
   input wire logic         i_sys_clk,
   input wire logic         i_resetn,
   input wire logic         o_txd,
   input wire logic         i_remote_mode,
   input wire logic [3:0]   i_frame_sw,
   input wire logic [3:0]   i_baud_sw,
   input wire logic         i_ext_sp_sel,
   input wire logic         o_rx_valid,
   input wire logic         i_tx_valid,
   input wire logic         o_tx_ready,
   input wire logic         i_sp_load,
   input wire logic [11:0]  i_sp_value,
   input wire logic [11:0]  i_ext_setpoint,
   input wire logic [11:0]  o_setpoint,
   input wire logic         i_ovr_valid,
   input wire vsp_ovr_cmd_t i_ovr_cmd,
   input wire vsp_ovr_t     o_ovr,
   input wire vsp_frame_t   o_frame,
   input wire logic         o_cfg_done
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   logic [31:0] lo_cnt;
   // Length of the current low stretch on the zero line
   always_ff @(posedge i_sys_clk or negedge i_resetn)
      if (!i_resetn)
         lo_cnt <= '0;
      else if (o_ovr.zero_n)
         lo_cnt <= '0;
      else
         lo_cnt <= lo_cnt + 1;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   chk_rx_local_mode: assert property ((!i_remote_mode)[*6] |-> !o_rx_valid)
      else $error("byte delivered in local mode");
   chk_ovr_local_mode: assert property ((!i_remote_mode)[*4] ##0 i_ovr_valid |=>
      $stable({o_ovr.open_n, o_ovr.close_n, o_ovr.halt_n, o_ovr.posn_n}))
      else $error("override taken in local mode");
   chk_ovr_open_cmd: assert property (i_remote_mode[*4] ##0 (i_ovr_valid && i_ovr_cmd == OVR_OPEN)
      |=> !o_ovr.open_n && o_ovr.close_n && o_ovr.halt_n && o_ovr.posn_n)
      else $error("open command not applied");
   chk_zero_hold_len: assert property ($rose(o_ovr.zero_n) |-> lo_cnt >= ZERO_HOLD_CYC - 1)
      else $error("zero line released early");
   chk_sp_link_load: assert property ((i_remote_mode && !i_ext_sp_sel)[*4] ##0 i_sp_load
      ##1 (!i_ext_sp_sel)[*2] |-> o_setpoint == $past(i_sp_value, 2))
      else $error("link set point not applied");
   chk_sp_ext_follow: assert property ((o_cfg_done && i_ext_sp_sel)[*4]
      |-> o_setpoint == $past(i_ext_setpoint))
      else $error("external set point not followed");
   chk_frame_held: assert property (o_cfg_done && $past(o_cfg_done) |-> $stable(o_frame))
      else $error("framing changed after capture");
   chk_ready_cfg: assert property (!o_cfg_done |-> !o_tx_ready)
      else $error("transmitter ready before capture");
   chk_tx_start_bit: assert property (o_tx_ready && i_tx_valid |=> !o_txd && !o_tx_ready)
      else $error("start bit missing");
   chk_tx_idle_high: assert property (o_tx_ready |-> o_txd)
      else $error("line not idle high");
   chk_dflt_frame: assert property ($rose(o_cfg_done) && i_frame_sw == 4'hD && i_baud_sw == 4'h7
      |-> o_frame == 8'hC7)
      else $error("default framing wrong");
   chk_par_off_odd: assert property (o_cfg_done && !o_frame.par_en |-> !o_frame.par_odd)
      else $error("parity sense kept while off");
   chk_len_stop: assert property ($rose(o_cfg_done) |-> o_frame.seven == i_frame_sw[0]
      && o_frame.two_stop == !i_frame_sw[2])
      else $error("length or stop poles wrong");
endmodule // vsp_port_properties
`default_nettype wire
